/* core/dma_ctrl_pkg.sv */
// Shared constants for the seven-channel transfer controller.
// Assumes a 32-bit word register port and byte addresses.
package dma_ctrl_pkg;

  // ----------------------------------------------------------------------
  // geometry and register map
  // ----------------------------------------------------------------------
  localparam int         NUM_CH          = 7;
  localparam int         FLAGS_PER_CH    = 4;
  localparam int         STAT_W          = 28;
  localparam int         CFG_W           = 15;
  localparam int         CNT_W           = 16;
  localparam logic [7:0] REG_STATUS      = 8'h00;
  localparam logic [7:0] REG_CLEAR       = 8'h04;
  localparam logic [7:0] REG_CFG_BASE    = 8'h08;
  localparam logic [7:0] REG_COUNT_BASE  = 8'h0c;
  localparam logic [7:0] REG_PADDR_BASE  = 8'h10;
  localparam logic [7:0] REG_MADDR_BASE  = 8'h14;
  localparam logic [7:0] CH_STRIDE       = 8'h14;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int FLAG_ANY   = 0;
  localparam int FLAG_DONE  = 1;
  localparam int FLAG_HALF  = 2;
  localparam int FLAG_FAULT = 3;
  localparam int CFG_EN     = 0;
  localparam int CFG_DONE_IE  = 1;
  localparam int CFG_HALF_IE  = 2;
  localparam int CFG_FAULT_IE = 3;
  localparam int CFG_DIR    = 4;
  localparam int CFG_CIRC   = 5;
  localparam int CFG_PSTEP  = 6;
  localparam int CFG_MSTEP  = 7;
  localparam int CFG_PW_LO  = 8;
  localparam int CFG_MW_LO  = 10;
  localparam int CFG_PRIO_LO = 12;
  localparam int CFG_M2M    = 14;

  // ----------------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [CFG_W-1:0]  CFG_RESET    = 15'h0000;
  localparam logic [STAT_W-1:0] STAT_RESET   = 28'h0000000;
  localparam logic [1:0]        GAP_CYCLES   = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_READ   = 3'b001,
    ST_WRITE  = 3'b010,
    ST_FINISH = 3'b011,
    ST_GAP    = 3'b100
  } eng_state_t;

  // item width code to address step in bytes; reserved code steps by 4
  function automatic logic [31:0] stepBytes(input logic [1:0] w);
    unique case (w)
      2'h0:    stepBytes = 32'h1;
      2'h1:    stepBytes = 32'h2;
      default: stepBytes = 32'h4;
    endcase
  endfunction : stepBytes

endpackage : dma_ctrl_pkg

/* core/dma_priority_arbiter.sv */
// Picks one pending channel: higher software level first, then lowest number.
// Assumes pending and level inputs are stable in the cycle they are sampled.
`timescale 1ns/1ps
module dma_priority_arbiter
  import dma_ctrl_pkg::*;
(
  // requests
  input  wire logic [NUM_CH-1:0]   pend,
  input  wire logic [2*NUM_CH-1:0] prioFlat,
  // choice
  output logic [2:0]               grant,
  output logic                     grantValid
);

  logic [1:0] bestPrio;

  always_comb begin
    grant      = 3'h0;
    grantValid = 1'b0;
    bestPrio   = 2'h0;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (pend[ch] && (!grantValid || prioFlat[2*ch +: 2] > bestPrio)) begin
        grant      = 3'(ch);
        grantValid = 1'b1;
        bestPrio   = prioFlat[2*ch +: 2];
      end
    end
  end

endmodule : dma_priority_arbiter

/* core/dma_channel_flags_and_config.sv */
// Register file, event flags, arbiter hookup and item mover for 7 channels.
// Assumes a same-clock register port and memory bus; request pins are async.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module dma_channel_flags_and_config
  import dma_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // register port
  input  wire logic [7:0]        regAddr,
  input  wire logic [31:0]       regWdata,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic [31:0]            regRdata,
  // peripheral request lines
  input  wire logic [NUM_CH-1:0] periphReq,
  output logic [NUM_CH-1:0]      periphAck,
  // memory bus master
  output logic                   busReq,
  output logic                   busWe,
  output logic [31:0]            busAddr,
  output logic [1:0]             busSize,
  output logic [31:0]            busWdata,
  input  wire logic              busAck,
  input  wire logic              busErr,
  input  wire logic [31:0]       busRdata,
  // per-channel interrupt requests
  output logic [NUM_CH-1:0]      chanIrq
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [CFG_W-1:0]  cfg      [NUM_CH];
  logic [CNT_W-1:0]  cntStart [NUM_CH];
  logic [CNT_W-1:0]  cnt      [NUM_CH];
  logic [31:0]       pStart   [NUM_CH];
  logic [31:0]       pAddr    [NUM_CH];
  logic [31:0]       mStart   [NUM_CH];
  logic [31:0]       mAddr    [NUM_CH];
  logic [STAT_W-1:0] stat;
  logic [NUM_CH-1:0] reqMeta;
  logic [NUM_CH-1:0] reqSync;
  eng_state_t        state;
  logic [2:0]        cur;
  logic [1:0]        gap;
  logic              lastFault;

  logic [NUM_CH-1:0]   hitCfg;
  logic [NUM_CH-1:0]   hitCnt;
  logic [NUM_CH-1:0]   hitPa;
  logic [NUM_CH-1:0]   hitMa;
  logic [NUM_CH-1:0]   pend;
  logic [2*NUM_CH-1:0] prioFlat;
  logic [2:0]          grant;
  logic                grantValid;
  logic [NUM_CH-1:0]   evDone;
  logic [NUM_CH-1:0]   evHalf;
  logic [NUM_CH-1:0]   evFault;
  logic                itemDone;
  logic                faultHit;
  logic [2:0]          selCh;
  logic [31:0]         srcAddr;
  logic [31:0]         dstAddr;
  logic [1:0]          srcW;
  logic [1:0]          dstW;
  logic [31:0]         next_rdata;
  logic                clrWr;

  function automatic logic [7:0] chBase(input logic [7:0] base, input int ch);
    chBase = base + 8'(ch * 20);
  endfunction : chBase

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  always_comb begin
    for (int ch = 0; ch < NUM_CH; ch++) begin
      hitCfg[ch] = regAddr == chBase(REG_CFG_BASE, ch);
      hitCnt[ch] = regAddr == chBase(REG_COUNT_BASE, ch);
      hitPa[ch]  = regAddr == chBase(REG_PADDR_BASE, ch);
      hitMa[ch]  = regAddr == chBase(REG_MADDR_BASE, ch);
    end
  end

  // ----------------------------------------------------------------------
  // request pin synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reqMeta <= '0;
      reqSync <= '0;
    end else begin
      reqMeta <= periphReq;
      reqSync <= reqMeta;
    end
  end

  // ----------------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------------
  always_comb begin
    for (int ch = 0; ch < NUM_CH; ch++) begin
      pend[ch] = cfg[ch][CFG_EN] && cnt[ch] != '0
                 && (cfg[ch][CFG_M2M] || reqSync[ch]);
      prioFlat[2*ch +: 2] = cfg[ch][CFG_PRIO_LO +: 2];
    end
  end

  dma_priority_arbiter u_arb (
    .pend       (pend),
    .prioFlat   (prioFlat),
    .grant      (grant),
    .grantValid (grantValid)
  );

  // ----------------------------------------------------------------------
  // source and destination of the selected channel
  // ----------------------------------------------------------------------
  always_comb begin
    selCh = (state == ST_IDLE) ? grant : cur;
    if (cfg[selCh][CFG_DIR]) begin
      srcAddr = mAddr[selCh];
      dstAddr = pAddr[selCh];
      srcW    = cfg[selCh][CFG_MW_LO +: 2];
      dstW    = cfg[selCh][CFG_PW_LO +: 2];
    end else begin
      srcAddr = pAddr[selCh];
      dstAddr = mAddr[selCh];
      srcW    = cfg[selCh][CFG_PW_LO +: 2];
      dstW    = cfg[selCh][CFG_MW_LO +: 2];
    end
  end

  assign itemDone = state == ST_WRITE && busAck && !busErr;
  assign faultHit = (state == ST_READ || state == ST_WRITE)
                    && busAck && busErr;

  always_comb begin
    for (int ch = 0; ch < NUM_CH; ch++) begin
      evDone[ch]  = itemDone && cur == 3'(ch) && cnt[ch] == 16'h0001;
      evHalf[ch]  = itemDone && cur == 3'(ch)
                    && (cnt[ch] - 16'h0001) == (cntStart[ch] >> 1);
      evFault[ch] = faultHit && cur == 3'(ch);
    end
  end

  // ----------------------------------------------------------------------
  // item mover
  // ----------------------------------------------------------------------
  // one item at a time; the gap lets a served peripheral drop its
  // request through the synchroniser before arbitration looks again
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      cur       <= 3'h0;
      gap       <= 2'h0;
      lastFault <= 1'b0;
      busReq    <= 1'b0;
      busWe     <= 1'b0;
      busAddr   <= 32'h0;
      busSize   <= 2'h0;
      busWdata  <= 32'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (grantValid) begin
            cur       <= grant;
            lastFault <= 1'b0;
            busReq    <= 1'b1;
            busWe     <= 1'b0;
            busAddr   <= srcAddr;
            busSize   <= srcW;
            state     <= ST_READ;
          end
        end
        ST_READ: begin
          if (busAck) begin
            if (busErr) begin
              busReq    <= 1'b0;
              lastFault <= 1'b1;
              state     <= ST_FINISH;
            end else begin
              busWe    <= 1'b1;
              busAddr  <= dstAddr;
              busSize  <= dstW;
              busWdata <= busRdata;
              state    <= ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          if (busAck) begin
            busReq    <= 1'b0;
            busWe     <= 1'b0;
            lastFault <= busErr;
            state     <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          gap   <= GAP_CYCLES;
          state <= ST_GAP;
        end
        ST_GAP: begin
          gap <= gap - 2'h1;
          if (gap == 2'h1) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      periphAck <= '0;
    end else if (state == ST_FINISH && !lastFault && !cfg[cur][CFG_M2M]) begin
      periphAck <= NUM_CH'(1) << cur;
    end else begin
      periphAck <= '0;
    end
  end

  // ----------------------------------------------------------------------
  // channel registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        cfg[ch]      <= CFG_RESET;
        cntStart[ch] <= '0;
        cnt[ch]      <= '0;
        pStart[ch]   <= 32'h0;
        pAddr[ch]    <= 32'h0;
        mStart[ch]   <= 32'h0;
        mAddr[ch]    <= 32'h0;
      end
    end else begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        if (regWrite && hitCfg[ch]) begin
          cfg[ch] <= regWdata[CFG_W-1:0];
        end else if (evFault[ch]) begin
          cfg[ch][CFG_EN] <= 1'b0;
        end
        // count and bases only while the channel is off
        if (!cfg[ch][CFG_EN] && regWrite && hitCnt[ch]) begin
          cntStart[ch] <= regWdata[CNT_W-1:0];
          cnt[ch]      <= regWdata[CNT_W-1:0];
        end else if (itemDone && cur == 3'(ch)) begin
          if (cnt[ch] == 16'h0001 && cfg[ch][CFG_CIRC]) begin
            cnt[ch] <= cntStart[ch];
          end else begin
            cnt[ch] <= cnt[ch] - 16'h0001;
          end
        end
        if (!cfg[ch][CFG_EN] && regWrite && hitPa[ch]) begin
          pStart[ch] <= regWdata;
          pAddr[ch]  <= regWdata;
        end else if (itemDone && cur == 3'(ch)) begin
          if (cnt[ch] == 16'h0001 && cfg[ch][CFG_CIRC]) begin
            pAddr[ch] <= pStart[ch];
          end else if (cfg[ch][CFG_PSTEP]) begin
            pAddr[ch] <= pAddr[ch] + stepBytes(cfg[ch][CFG_PW_LO +: 2]);
          end
        end
        if (!cfg[ch][CFG_EN] && regWrite && hitMa[ch]) begin
          mStart[ch] <= regWdata;
          mAddr[ch]  <= regWdata;
        end else if (itemDone && cur == 3'(ch)) begin
          if (cnt[ch] == 16'h0001 && cfg[ch][CFG_CIRC]) begin
            mAddr[ch] <= mStart[ch];
          end else if (cfg[ch][CFG_MSTEP]) begin
            mAddr[ch] <= mAddr[ch] + stepBytes(cfg[ch][CFG_MW_LO +: 2]);
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // event flags
  // ----------------------------------------------------------------------
  assign clrWr = regWrite && regAddr == REG_CLEAR;

  // a set in the same cycle as a clear wins, so no event is lost
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stat <= STAT_RESET;
    end else begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        stat[4*ch + FLAG_ANY] <=
          (stat[4*ch + FLAG_ANY] & ~(clrWr & regWdata[4*ch + FLAG_ANY]))
          | evDone[ch] | evHalf[ch] | evFault[ch];
        stat[4*ch + FLAG_DONE] <=
          (stat[4*ch + FLAG_DONE] & ~(clrWr & (regWdata[4*ch + FLAG_ANY]
          | regWdata[4*ch + FLAG_DONE]))) | evDone[ch];
        stat[4*ch + FLAG_HALF] <=
          (stat[4*ch + FLAG_HALF] & ~(clrWr & (regWdata[4*ch + FLAG_ANY]
          | regWdata[4*ch + FLAG_HALF]))) | evHalf[ch];
        stat[4*ch + FLAG_FAULT] <=
          (stat[4*ch + FLAG_FAULT] & ~(clrWr & (regWdata[4*ch + FLAG_ANY]
          | regWdata[4*ch + FLAG_FAULT]))) | evFault[ch];
      end
    end
  end

  // ----------------------------------------------------------------------
  // interrupt requests
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      chanIrq <= '0;
    end else begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        chanIrq[ch] <=
          (stat[4*ch + FLAG_DONE] & cfg[ch][CFG_DONE_IE])
          | (stat[4*ch + FLAG_HALF] & cfg[ch][CFG_HALF_IE])
          | (stat[4*ch + FLAG_FAULT] & cfg[ch][CFG_FAULT_IE]);
      end
    end
  end

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0;
    if (regAddr == REG_STATUS) begin
      next_rdata = {4'h0, stat};
    end
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (hitCfg[ch]) next_rdata = {17'h0, cfg[ch]};
      if (hitCnt[ch]) next_rdata = {16'h0, cnt[ch]};
      if (hitPa[ch])  next_rdata = pStart[ch];
      if (hitMa[ch])  next_rdata = mStart[ch];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      regRdata <= 32'h0;
    end else begin
      regRdata <= regRead ? next_rdata : 32'h0;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  AST_ANY_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (evDone[0] || evHalf[0] || evFault[0]) |=> stat[0])
    else $error("any-event flag not set after event");

  AST_DONE_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    evDone[1] |=> stat[5] && stat[4])
    else $error("done flag not set after completion");

  AST_HALF_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    evHalf[1] |=> stat[6])
    else $error("half flag not set after half event");

  AST_FAULT_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    faultHit && cur == 3'h0 |=> stat[3] ##[3:4] !busReq)
    else $error("fault flag missing or bus not released");

  AST_NO_SELF_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(stat[5]) |-> $past(evDone[1]))
    else $error("done flag rose without a completion");

  AST_CLEAR_ALL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    regWrite && regAddr == REG_CLEAR && regWdata[0]
    && !evDone[0] && !evHalf[0] && !evFault[0] |=> stat[3:0] == 4'h0)
    else $error("clear-all left a flag standing");

  AST_CLEAR_DONE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    regWrite && regAddr == REG_CLEAR && regWdata[11:8] == 4'h2
    && !evDone[2] && !evHalf[2] && !evFault[2]
    |=> !stat[9] && stat[8] == $past(stat[8]) && stat[10] == $past(stat[10]))
    else $error("done clear wrong");

  AST_IRQ_GATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    chanIrq[0] |-> $past((stat[1] & cfg[0][1]) | (stat[2] & cfg[0][2])
                         | (stat[3] & cfg[0][3])))
    else $error("interrupt raised without an enabled flag");

  AST_RSVD_CFG: assert property (@(posedge sys_clk) disable iff (!rst_n)
    regRead && hitCfg[0] |=> regRdata[31:15] == 17'h0
                             && regRdata[14:0] == $past(cfg[0]))
    else $error("configuration read wrong");

  AST_START_EN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == ST_IDLE && grantValid |-> cfg[grant][CFG_EN] ##1 busReq)
    else $error("disabled channel started");

endmodule : dma_channel_flags_and_config

/* verif/dma_mem_model.sv */
// Far side: memory bus responder and peripheral request source.
// Assumes one clock; read data is a fixed function of the address.
`timescale 1ns/1ps
module dma_mem_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // memory bus
  input  wire logic        busReq,
  input  wire logic        busWe,
  input  wire logic [31:0] busAddr,
  input  wire logic [31:0] busWdata,
  output logic             busAck,
  output logic             busErr,
  output logic [31:0]      busRdata,
  // requests
  input  wire logic [6:0]  periphAck,
  output logic [6:0]       periphReq,
  // bench control and view
  input  wire logic [1:0]  delay,
  input  wire logic        errOn,
  input  wire logic [6:0]  arm,
  output logic [31:0]      lastWrAddr,
  output logic [31:0]      lastWrData,
  output logic [7:0]       wrCount
);
  // ----------------
  // responder
  // ----------------
  logic [1:0]  waitCnt;
  logic [31:0] word;
  logic        hold;
  // off an ack the data lines show the inverse, never a stale word
  assign word     = {busAddr[15:0], ~busAddr[15:0]};
  assign busRdata = busAck ? word : ~word;
  assign busErr   = busAck & errOn;
  assign hold     = busReq && !busAck;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busAck    <= 1'b0;
      waitCnt   <= 2'h0;
      periphReq <= 7'h00;
      wrCount   <= 8'h00;
    end else begin
      // request held until served, dropped on the ack pulse
      periphReq <= (periphReq | arm) & ~periphAck;
      busAck    <= hold && waitCnt == delay;
      waitCnt   <= (hold && waitCnt != delay) ? waitCnt + 2'h1 : 2'h0;
      if (busAck && busWe) begin
        lastWrAddr <= busAddr;
        lastWrData <= busWdata;
        wrCount    <= wrCount + 8'h01;
      end
    end
  end
endmodule : dma_mem_model

/* verif/tb.sv */
// Self-checking bench for the seven-channel transfer controller.
// Assumes the far-side model answers the bus and raises requests.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin \
  err_count++; $display("BAD %s exp %h got %h", what, exp, got); end end
module tb;
  // ----------------
  // signals
  // ----------------
  logic        sys_clk = 1'b0, rst_n = 1'b0, errOn = 1'b0;
  logic        regWrite = 1'b0, regRead = 1'b0, busReq, busWe, busAck, busErr;
  logic [1:0]  delay = 2'h0, busSize, p4, p6, pw;
  logic [6:0]  arm = 7'h0, periphReq, periphAck, chanIrq;
  logic [7:0]  regAddr = 8'h0, wrCount;
  logic [31:0] regWdata = 32'h0, regRdata, busAddr, busWdata, busRdata;
  logic [31:0] lastWrAddr, lastWrData, d, v;
  int          err_count = 0, compares = 0, cycles = 0, n;
  dma_channel_flags_and_config dut (.sys_clk, .rst_n, .regAddr, .regWdata,
    .regWrite, .regRead, .regRdata, .periphReq, .periphAck, .busReq, .busWe,
    .busAddr, .busSize, .busWdata, .busAck, .busErr, .busRdata, .chanIrq);
  dma_mem_model far (.sys_clk, .rst_n, .busReq, .busWe, .busAddr, .busWdata,
    .busAck, .busErr, .busRdata, .periphAck, .periphReq, .delay, .errOn,
    .arm, .lastWrAddr, .lastWrData, .wrCount);
  always #4 sys_clk = ~sys_clk;
  // ----------------
  // helpers
  // ----------------
  task automatic test_done;
    if (err_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end
  // k: 0 configuration, 1 count, 2 peripheral and 3 memory address
  function automatic logic [7:0] chA(input int c, input int k);
    return 8'(8 + 20 * (c - 1) + 4 * k);
  endfunction : chA
  // far-side memory content: address over its inverse
  function automatic logic [31:0] memWord(input logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction : memWord
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    regAddr <= a;
    regWdata <= w;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  // data sampled mid-cycle, so no race with the edge that drops it
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    @(negedge sys_clk) r = regRdata;
    @(posedge sys_clk);
  endtask : rd
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    rd(a, r);
    `CHK($sformatf("reg %h", a), e, r)
  endtask : chk
  task automatic waitSt(input logic [31:0] m);
    int k;
    k = 0;
    rd(8'h00, d);
    while ((d & m) !== m && k < 100) begin
      rd(8'h00, d);
      k++;
    end
  endtask : waitSt
  task automatic setCh(input int c, input logic [31:0] cnt, pa, ma, cfg);
    wr(chA(c, 0), 32'h0);
    wr(chA(c, 1), cnt);
    wr(chA(c, 2), pa);
    wr(chA(c, 3), ma);
    wr(chA(c, 0), cfg);
  endtask : setCh
  // ----------------
  // sequence
  // ----------------
  initial begin
    void'($urandom(70));
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk(8'h00, 32'h0);
    chk(8'h04, 32'h0);
    chk(8'hfc, 32'h0);
    for (int c = 1; c <= 7; c++) begin
      v = $urandom & 32'hfffffffe;
      wr(chA(c, 0), v);
      chk(chA(c, 0), v & 32'h7ffe);
      wr(chA(c, 0), 32'h0);
    end
    wr(8'h00, 32'hffffffff);
    chk(8'h00, 32'h0);
    // memory to memory, two 32-bit items, stepping both sides
    delay <= 2'($urandom);
    setCh(3, 2, 32'h1000, 32'h2000, 32'h4ac3);
    waitSt(32'h200);
    chk(8'h00, 32'h700);
    chk(chA(3, 1), 32'h0);
    `CHK("wrCount", 8'h2, wrCount)
    `CHK("wrAddr", 32'h2004, lastWrAddr)
    `CHK("wrData", memWord(32'h1004), lastWrData)
    `CHK("irq", 7'h4, chanIrq)
    wr(8'h04, 32'h200);
    chk(8'h00, 32'h500);
    `CHK("irq", 7'h0, chanIrq)
    wr(8'h04, 32'h400);
    chk(8'h00, 32'h100);
    wr(8'h04, 32'h100);
    chk(8'h00, 32'h0);
    wr(chA(3, 0), 32'h0);
    // bus fault on the first read, memory to peripheral
    errOn <= 1'b1;
    setCh(1, 1, 32'h100, 32'h300, 32'h19);
    arm <= 7'h01;
    @(posedge sys_clk);
    arm <= 7'h00;
    waitSt(32'h8);
    chk(8'h00, 32'h9);
    chk(chA(1, 0), 32'h18);
    `CHK("irq", 7'h1, chanIrq)
    `CHK("wrCount", 8'h2, wrCount)
    errOn <= 1'b0;
    wr(8'h04, 32'h8);
    chk(8'h00, 32'h1);
    wr(8'h04, 32'h1);
    // circular, 16-bit items, both pointers stepping, one item per request
    setCh(2, 2, 32'h200, 32'h500, 32'h5e1);
    for (int i = 0; i < 3; i++) begin
      wr(8'h04, 32'h10);
      arm <= 7'h02;
      @(posedge sys_clk);
      arm <= 7'h00;
      waitSt((i == 1) ? 32'h20 : 32'h40);
      v = (i == 1) ? 32'h2 : 32'h0;
      `CHK("cAddr", 32'h500 + v, lastWrAddr)
      `CHK("cData", memWord(32'h200 + v), lastWrData)
      chk(chA(2, 1), (i == 1) ? 32'h2 : 32'h1);
    end
    wr(chA(2, 0), 32'h0);
    wr(8'h04, 32'h10);
    // two requests at once; first pass uses equal levels
    for (int i = 0; i < 4; i++) begin
      p4 = (i == 0) ? 2'h1 : 2'($urandom);
      p6 = (i == 0) ? 2'h1 : 2'($urandom);
      // no I2C channel here, so any of width codes 0 to 2 may be used; the reserved code 3 is not drawn
      pw = 2'($urandom % 3);
      delay <= 2'($urandom);
      setCh(4, 1, 32'h400, 32'h800, {18'h0, p4, 2'h0, pw, 8'h41});
      setCh(6, 1, 32'h600, 32'h900, {18'h0, p6, 2'h0, pw, 8'h41});
      arm <= 7'h28;
      @(posedge sys_clk);
      arm <= 7'h00;
      n = 0;
      while (busReq !== 1'b1 && n < 50) begin
        @(negedge sys_clk);
        n++;
      end
      `CHK("first", (p6 > p4) ? 32'h600 : 32'h400, busAddr)
      `CHK("size", pw, busSize)
      @(posedge sys_clk);
      waitSt(32'h202000);
      chk(8'h00, 32'h707000);
      wr(8'h04, 32'hffffffff);
      chk(8'h00, 32'h0);
    end
    test_done();
  end
endmodule : tb
